// [dv/hbh_host.sv]
// Host processor model: drives the bus request and select pins.
// Assumes the bench sets its wishes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module hbh_host (
  // Clock.
  input wire logic ref_clk,
  // Bench wishes.
  input wire logic want_bus,
  input wire logic want_sel,
  // Host pins, idle high.
  output logic host_bus_request_n = 1'b1,
  output logic host_chip_select_n = 1'b1
);
  // Pins move only after an edge, so the device never sees a glitch.
  always @(posedge ref_clk) begin
    host_bus_request_n <= !want_bus;
    host_chip_select_n <= !want_sel;
  end
endmodule
`default_nettype wire

// [dv/host_bus_handoff_tb.sv]
// Self-checking bench for the host bus handoff block.
// Assumes pull-ups on the grant and ready pins.
`timescale 1ns/1ps
`default_nettype none
module host_bus_handoff_tb;
  import hbh_pkg::*;
  logic ref_clk = 0, resetn = 0, want_bus = 0, want_sel = 0, mst = 1;
  logic [NUM_PROC-1:0] preq_n = '1;
  wire logic req_n, cs_n, g_o, g_oe, r_o, r_oe, bus_oe, arb;
  wire logic [ADDR_W-1:0] addr_o;
  wire logic [DATA_W-1:0] data_o;
  wire logic [SEL_W-1:0] sel_o;
  wire logic [STRB_W-1:0] strb_o;
  // Fixed values the device copies onto the bus while it owns it.
  localparam logic [ADDR_W-1:0] ADDR_V = 24'h12_3456;
  localparam logic [DATA_W-1:0] DATA_V = 32'h89ab_cdef;
  localparam logic [SEL_W-1:0] SEL_V = 4'h5;
  localparam logic [STRB_W-1:0] STRB_V = 2'h1;
  // Pulled-up pins float high when nobody drives them.
  wire logic g_pin = g_oe ? g_o : 1'b1;
  wire logic r_pin = r_oe ? r_o : 1'b1;
  int err_count = 0, total_checks = 0;
  // Free-running 250 MHz clock.
  always #2 ref_clk = ~ref_clk;
  hbh_host i_hbh_host (.ref_clk(ref_clk), .want_bus(want_bus),
    .want_sel(want_sel), .host_bus_request_n(req_n),
    .host_chip_select_n(cs_n));
  hbh_top i_hbh_top (.ref_clk(ref_clk), .resetn(resetn),
    .host_bus_request_n(req_n), .host_chip_select_n(cs_n),
    .processor_bus_requests_n(preq_n), .bus_master(mst),
    .bus_addr_d(ADDR_V), .bus_data_d(DATA_V),
    .bus_sel_d(SEL_V), .bus_strb_d(STRB_V), .bus_addr_o(addr_o),
    .bus_data_o(data_o), .bus_sel_o(sel_o), .bus_strb_o(strb_o),
    .bus_oe(bus_oe),
    .host_bus_grant_n_i(g_pin), .host_bus_grant_n_o(g_o),
    .host_bus_grant_n_oe(g_oe), .host_access_ready_o(r_o),
    .host_access_ready_oe(r_oe), .proc_arb_enable(arb));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Grant with processors also asking; count float cycles.
  task automatic t_grant();
    int fl;
    fl = 0;
    @(posedge ref_clk) begin
      want_bus <= 1'b1;
      preq_n <= '0;
    end
    for (int i = 0; i < 12 && g_pin !== 1'b0; i++) begin
      @(negedge ref_clk);
      if (g_oe === 1'b0) fl++;
    end
    chk(g_pin, 32'h0);
    chk(fl, 32'h1);
    chk(bus_oe, 32'h0);
    chk(arb, 32'h0);
    repeat (6) begin
      @(negedge ref_clk);
      chk(g_pin, 32'h0);
    end
    @(posedge ref_clk) want_bus <= 1'b0;
    // The grant must stay low until the very cycle arbitration resumes.
    for (int i = 0; i < 12 && arb !== 1'b1; i++) begin
      @(negedge ref_clk);
      if (arb !== 1'b1) chk(g_pin, 32'h0);
    end
    chk(arb, 32'h1);
    chk(bus_oe, 32'h1);
    chk(g_pin, 32'h1);
    @(negedge ref_clk);
    chk(g_pin, 32'h1);
    @(posedge ref_clk) preq_n <= '1;
  endtask
  // A device that is not bus master never drives the grant.
  task automatic t_slave();
    @(posedge ref_clk) begin
      mst <= 1'b0;
      want_bus <= 1'b1;
    end
    // The edge above still saw the old master level, so skip one cycle.
    @(posedge ref_clk);
    repeat (8) begin
      @(negedge ref_clk);
      chk(g_oe, 32'h0);
    end
    @(posedge ref_clk) want_bus <= 1'b0;
    repeat (6) @(posedge ref_clk);
    mst <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
  // Select alone gives no wait state; select with request does.
  task automatic t_ready();
    @(posedge ref_clk) want_sel <= 1'b1;
    repeat (6) begin
      @(negedge ref_clk);
      chk(r_pin, 32'h1);
    end
    @(posedge ref_clk) want_bus <= 1'b1;
    for (int i = 0; i < 8 && r_pin !== 1'b0; i++) @(negedge ref_clk);
    chk(r_pin, 32'h0);
    @(posedge ref_clk) want_bus <= 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(r_pin, 32'h1);
    @(posedge ref_clk) want_sel <= 1'b0;
  endtask
  // A reset in mid-grant floats the grant and restarts the handoff.
  task automatic t_reset();
    int fl;
    fl = 0;
    @(posedge ref_clk) want_bus <= 1'b1;
    for (int i = 0; i < 12 && g_pin !== 1'b0; i++) @(negedge ref_clk);
    chk(g_pin, 32'h0);
    @(posedge ref_clk) resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(g_oe, 32'h0);
    chk(bus_oe, 32'h0);
    chk(arb, 32'h1);
    @(posedge ref_clk) resetn <= 1'b1;
    // The reset itself leaves the grant floating for one more edge.
    @(posedge ref_clk);
    for (int i = 0; i < 12 && g_pin !== 1'b0; i++) begin
      @(negedge ref_clk);
      if (g_oe === 1'b0) fl++;
    end
    chk(g_pin, 32'h0);
    chk(fl, 32'h1);
    @(posedge ref_clk) want_bus <= 1'b0;
    for (int i = 0; i < 12 && arb !== 1'b1; i++) @(negedge ref_clk);
    chk(g_pin, 32'h1);
  endtask
  // Main sequence after a 20-cycle reset.
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(g_pin, 32'h1);
    chk(arb, 32'h1);
    chk(bus_oe, 32'h1);
    chk(addr_o, ADDR_V);
    chk(data_o, DATA_V);
    chk(sel_o, SEL_V);
    chk(strb_o, STRB_V);
    t_grant();
    t_slave();
    t_ready();
    t_reset();
    end_sim();
  end
  // Watchdog: the tests need a few hundred cycles at most.
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire

// [include/hbh_pkg.sv]
// Shared constants and types for the host bus handoff block.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
package hbh_pkg;
  // Clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // The grant line floats for one input clock cycle before it is driven.
  localparam int unsigned GRANT_FLOAT_CYCLES = 1;
  localparam logic [1:0] GRANT_FLOAT_CNT = 2'(GRANT_FLOAT_CYCLES);
  // Number of processor bus request lines in a multiprocessing system.
  localparam int unsigned NUM_PROC = 6;
  // Width of the external bus handed over to the host.
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned STRB_W = 2;
  // Value of the two-stage synchroniser after reset (lines idle high).
  localparam logic SYNC_RESET = 1'b1;
  // Handoff sequencer states.
  typedef enum logic [1:0] {
    HBH_IDLE,
    HBH_RELEASE,
    HBH_GRANT
  } hbh_state_t;
endpackage

// [rtl/hbh_sync.sv]
// Two-flip-flop synchroniser for a vector of asynchronous pin inputs.
// Assumes the inputs are idle high; reset loads the idle level.
`timescale 1ns/1ps
`default_nettype none
module hbh_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Raw and synchronised levels.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  import hbh_pkg::*;
  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage to contain metastability.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= {W{SYNC_RESET}};
      sync_out <= {W{SYNC_RESET}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [rtl/hbh_top.sv]
// Host bus handoff: grants the external bus to a host processor.
// Assumes pins are external and asynchronous; one 250 MHz clock.
// What this block does
// RQ1: Host drives active-low request to take bus.
// RQ2: Master releases bus, then asserts host grant.
// RQ3: Released address, data, selects, strobes float.
// RQ4: Host request outranks all processor requests.
// RQ5: Grant held low while request stays asserted.
// RQ6: Only the bus master drives the grant.
// RQ7: Grant floats one clock before being driven.
// RQ8: Host asserts chip select to access device.
// RQ9: Ready pulled low while select and request asserted.
// RQ10: Release ends grant, arbitration resumes next cycle.
`timescale 1ns/1ps
`default_nettype none
module hbh_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Host side pins, asynchronous.
  input wire logic host_bus_request_n,
  input wire logic host_chip_select_n,
  // Processor bus requests, asynchronous, active low.
  input wire logic [hbh_pkg::NUM_PROC-1:0] processor_bus_requests_n,
  // This device is the current bus master when high.
  input wire logic bus_master,
  // Internal bus drive values from the external port.
  input wire logic [hbh_pkg::ADDR_W-1:0] bus_addr_d,
  input wire logic [hbh_pkg::DATA_W-1:0] bus_data_d,
  input wire logic [hbh_pkg::SEL_W-1:0] bus_sel_d,
  input wire logic [hbh_pkg::STRB_W-1:0] bus_strb_d,
  // External bus outputs and their enable.
  output logic [hbh_pkg::ADDR_W-1:0] bus_addr_o,
  output logic [hbh_pkg::DATA_W-1:0] bus_data_o,
  output logic [hbh_pkg::SEL_W-1:0] bus_sel_o,
  output logic [hbh_pkg::STRB_W-1:0] bus_strb_o,
  output logic bus_oe,
  // Host grant pin, three signals.
  input wire logic host_bus_grant_n_i,
  output logic host_bus_grant_n_o,
  output logic host_bus_grant_n_oe,
  // Open-drain ready pin.
  output logic host_access_ready_o,
  output logic host_access_ready_oe,
  // Processor arbitration is allowed when high.
  output logic proc_arb_enable
);
  import hbh_pkg::*;

  logic hreq_s;
  logic cs_s;
  logic [NUM_PROC-1:0] preq_s;
  hbh_state_t state_q;
  logic [1:0] float_cnt_q;
  logic host_req;

  // The request and select pin inputs pass two flip-flops before use.
  hbh_sync #(.W(NUM_PROC + 2)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({host_bus_request_n, host_chip_select_n,
               processor_bus_requests_n}),
    .sync_out({hreq_s, cs_s, preq_s})
  );

  assign host_req = !hreq_s; // Host asks for the bus. [RQ1]

  // Sequencer: release the bus, float the grant one cycle, then grant.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= HBH_IDLE;
      float_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        HBH_IDLE: begin
          if (host_req && bus_master) begin // [RQ2] [RQ4]
            state_q <= HBH_RELEASE;
            float_cnt_q <= GRANT_FLOAT_CNT;
          end
        end
        HBH_RELEASE: begin
          if (!host_req) begin
            state_q <= HBH_IDLE;
          end else if (float_cnt_q == 2'h1) begin // [RQ7]
            state_q <= HBH_GRANT;
          end else begin
            float_cnt_q <= float_cnt_q - 2'h1;
          end
        end
        HBH_GRANT: begin
          if (!host_req) begin // [RQ5] [RQ10]
            state_q <= HBH_IDLE;
          end
        end
        default: state_q <= HBH_IDLE;
      endcase
    end
  end

  // Grant pin: driven only by the master, floated in the release cycle.
  // The external pull-up holds the line high while it floats.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      host_bus_grant_n_o <= 1'b1;
      host_bus_grant_n_oe <= 1'b0;
    end else begin
      host_bus_grant_n_o <= !(state_q == HBH_RELEASE && host_req &&
                              float_cnt_q == 2'h1) &&
                            !(state_q == HBH_GRANT && host_req); // [RQ5]
      host_bus_grant_n_oe <= bus_master &&
                             !(state_q == HBH_IDLE && host_req); // [RQ6] [RQ7]
    end
  end

  // External bus floats whenever the host owns it or handoff runs.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bus_addr_o <= '0;
      bus_data_o <= '0;
      bus_sel_o <= '0;
      bus_strb_o <= '0;
      bus_oe <= 1'b0;
    end else begin
      bus_addr_o <= bus_addr_d;
      bus_data_o <= bus_data_d;
      bus_sel_o <= bus_sel_d;
      bus_strb_o <= bus_strb_d;
      bus_oe <= bus_master && !host_req; // [RQ3]
    end
  end

  // Processor arbitration pauses while the host wants the bus.
  // Requests are not queued here; the arbiter samples them itself.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      proc_arb_enable <= 1'b1;
    end else begin
      proc_arb_enable <= !host_req; // [RQ4] [RQ10]
    end
  end

  // Ready is open drain: low inserts wait states for register access.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      host_access_ready_o <= 1'b0;
      host_access_ready_oe <= 1'b0;
    end else begin
      host_access_ready_o <= 1'b0;
      host_access_ready_oe <= !cs_s && host_req; // [RQ8] [RQ9]
    end
  end

  // Checks.
  sequence req_seen_s;
    state_q == HBH_IDLE && host_req && bus_master;
  endsequence
  sequence float_then_drive_s;
    !host_bus_grant_n_oe ##1 host_bus_grant_n_oe;
  endsequence

  // The float counts from the edge on which the sequencer sees the request.
  property float_one_p;
    @(posedge ref_clk) disable iff (!resetn)
      req_seen_s ##1 bus_master |-> float_then_drive_s;
  endproperty
  grant_float_a: assert property (float_one_p) // [RQ7]
    else $error("Grant did not float exactly one cycle.");

  grant_held_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q == HBH_GRANT && host_req |=> !host_bus_grant_n_o) // [RQ5]
    else $error("Grant dropped while request held.");

  grant_release_a: assert property (@(posedge ref_clk) // [RQ10]
    disable iff (!resetn)
    state_q == HBH_GRANT && !host_req |=> host_bus_grant_n_o &&
      proc_arb_enable)
    else $error("Grant not released after request ended.");

  bus_float_a: assert property (@(posedge ref_clk) // [RQ3]
    disable iff (!resetn) host_req |=> !bus_oe)
    else $error("Bus driven while host requests it.");

  master_only_a: assert property (@(posedge ref_clk) // [RQ6]
    disable iff (!resetn) !$past(bus_master) |-> !host_bus_grant_n_oe)
    else $error("Non-master drove the grant.");

  grant_after_release_a: assert property (@(posedge ref_clk) // [RQ2]
    disable iff (!resetn)
    !host_bus_grant_n_o && host_bus_grant_n_oe |-> !bus_oe)
    else $error("Grant given before bus released.");

  host_priority_a: assert property (@(posedge ref_clk) // [RQ4]
    disable iff (!resetn) host_req |=> !proc_arb_enable)
    else $error("Processor arbitration ran during host request.");

  ready_wait_a: assert property (@(posedge ref_clk) // [RQ9]
    disable iff (!resetn) !cs_s && host_req |=>
      host_access_ready_oe && !host_access_ready_o)
    else $error("Ready not pulled low during host access.");

  // Processor requests must not delay a host handoff.
  host_wins_a: assert property (@(posedge ref_clk) // [RQ4]
    disable iff (!resetn)
    req_seen_s && !(&preq_s) |=> state_q == HBH_RELEASE)
    else $error("Processor request delayed the host handoff.");

  // Without both select and request the ready line is released.
  ready_idle_a: assert property (@(posedge ref_clk) // [RQ9]
    disable iff (!resetn)
    cs_s || !host_req |=> !host_access_ready_oe)
    else $error("Ready held low without a host access.");

  // Once the host lets go, the master drives the bus again.
  bus_resume_a: assert property (@(posedge ref_clk) // [RQ10]
    disable iff (!resetn)
    !host_req && bus_master |=> bus_oe)
    else $error("Bus not resumed after host release.");

  // An idle master drives the grant line high, never low.
  grant_idle_a: assert property (@(posedge ref_clk) // [RQ6]
    disable iff (!resetn)
    state_q == HBH_IDLE |=> host_bus_grant_n_o)
    else $error("Grant driven low outside a handoff.");

  // The pin read back must match what this device drives onto it.
  grant_pin_a: assert property (@(posedge ref_clk) // [RQ6]
    disable iff (!resetn)
    host_bus_grant_n_oe |-> host_bus_grant_n_i == host_bus_grant_n_o)
    else $error("Grant pin does not follow the driven value.");
endmodule
`default_nettype wire
